// ---- urm_consts.svh ----
// Register offsets, field positions, reset values and counts of the serial port
`ifndef URM_CONSTS_SVH
`define URM_CONSTS_SVH

// ==============================
// Register offsets
`define URM_OFS_DATA     3'h0
`define URM_OFS_IER      3'h1
`define URM_OFS_IIR_FCR  3'h2
`define URM_OFS_LCR      3'h3
`define URM_OFS_MCR      3'h4
`define URM_OFS_LSR      3'h5
`define URM_OFS_MSR      3'h6
`define URM_OFS_SCR      3'h7

// ==============================
// Field positions
`define URM_LCR_DIVISOR_LATCH_ACCESS     7
`define URM_LCR_BREAK    6
`define URM_LCR_STICK    5
`define URM_LCR_EPS      4
`define URM_LCR_PEN      3
`define URM_LCR_STB      2
`define URM_MCR_LOOP     4
`define URM_MCR_AUX_OUTPUT_TWO     3
`define URM_MCR_AUX_OUTPUT_ONE     2
`define URM_MCR_RTS      1
`define URM_MCR_DTR      0
`define URM_FCR_EN       0
`define URM_FCR_RXCLR    1
`define URM_FCR_TXCLR    2
`define URM_FCR_DMA      3

// ==============================
// Interrupt identities, highest priority first
`define URM_IID_LINE     3'h3
`define URM_IID_RXDATA   3'h2
`define URM_IID_TX_HOLDING_EMPTY     3'h1
`define URM_IID_MODEM    3'h0

// ==============================
// Reset values and counts
`define URM_RST_BYTE     8'h00
`define URM_FIFO_DEPTH   16
`define URM_OVS_LAST     4'hF
`define URM_OVS_HALF     4'h7
`define URM_TRIG_1       5'h01
`define URM_TRIG_4       5'h04
`define URM_TRIG_8       5'h08
`define URM_TRIG_14      5'h0E

`endif

// ---- urm_pkg.sv ----
// Types shared by the serial port logic
package urm_pkg;

	// Gray sequence along idle, start, data, parity, stop
	typedef enum logic [2:0] {
		URM_IDLE  = 3'h0,
		URM_START = 3'h1,
		URM_DATA  = 3'h3,
		URM_PAR   = 3'h2,
		URM_STOP  = 3'h6
	} urm_ser_state_type;

endpackage

// ---- urm_uart.sv ----
// Serial port register set with its FIFOs, baud generator, transmitter and receiver
// Behaviour
// R01: Line control bit 7 switches offsets 0 and 1 to the divisor bytes.
// R02: Characters go out and come in least significant bit first.
// R03: In XT mode transmitter-empty follows only the shift register being idle.
// R04: Both auxiliary modem control outputs are storage only, driving no pin.
// R05: In XT mode the scratch register at offset 7 is unavailable.
// R06: Non-FIFO mode reads zero in FIFO-enabled, top ID and FIFO error bits.
// R07: Writing one to the DMA mode bit does nothing.
// R08: Receive buffer is read-only at offset 0 while divisor access is zero.
// R09: Clearing FIFO enable disables both FIFOs and discards their contents.
// R10: Receive FIFO clear empties it, leaves the shifter, and self-clears.
// R11: FIFO control bits 7:6 pick receive trigger of 1, 4, 8 or 14.
// R12: Transmit shifter loads from holding only after the previous byte finished.
// R13: Data ready sets on a received character, clears when all data is read.
// R14: Identification bit 0 reads zero while an enabled interrupt is pending.
`timescale 1ns/1ps
`include "urm_consts.svh"

// ==============================
// Synchronous FIFO
module urm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `URM_FIFO_DEPTH,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             mclk_i,
	input  wire logic             srst_i,
	input  wire logic             ce_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i,
	output logic      [AW:0]      count_o
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} urm_fifo_state_type;

	urm_fifo_state_type s_reg;
	urm_fifo_state_type s_next;
	logic               push;
	logic               pop;

	assign in_ready_o  = (s_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (s_reg.cnt != '0);
	assign out_data_o  = s_reg.mem[s_reg.rp];
	assign count_o     = s_reg.cnt;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;

	always_comb
	begin
		s_next = s_reg;
		if (flush_i)
		begin
			s_next.wp  = '0;
			s_next.rp  = '0;
			s_next.cnt = '0;
		end
		else
		begin
			if (push)
			begin
				s_next.mem[s_reg.wp] = in_data_i;
				s_next.wp = AW'(s_reg.wp + 1'b1);
			end
			if (pop)
				s_next.rp = AW'(s_reg.rp + 1'b1);
			if (push & ~pop)
				s_next.cnt = (AW+1)'(s_reg.cnt + 1'b1);
			else if (pop & ~push)
				s_next.cnt = (AW+1)'(s_reg.cnt - 1'b1);
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			s_reg <= '0;
		else if (ce_i)
			s_reg <= s_next;
	end
endmodule // urm_fifo

// ==============================
// Register set and serial engine
module urm_uart
	import urm_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       srst_i,
	input  wire logic       ce_i,
	input  wire logic [2:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	input  wire logic       xt_mode_i,
	input  wire logic       rx_i,
	output logic            tx_o,
	input  wire logic       cts_n_i,
	input  wire logic       dsr_n_i,
	input  wire logic       ri_n_i,
	input  wire logic       dcd_n_i,
	output logic            rts_n_o,
	output logic            dtr_n_o
);
	typedef struct packed {
		logic [3:0]        ier;
		logic [7:0]        lcr;
		logic [4:0]        mcr;
		logic [7:0]        dll;
		logic [7:0]        dlm;
		logic [7:0]        scr;
		logic              fifo_en;
		logic [1:0]        trig;
		logic [3:0]        lsr_err;
		logic [3:0]        msr_delta;
		logic [3:0]        msr_last;
		logic              tx_holding_empty_int;
		logic [15:0]       brg;
		logic              tick;
		urm_ser_state_type tx_st;
		logic [3:0]        tx_cnt;
		logic [2:0]        tx_bit;
		logic [7:0]        tx_sh;
		logic              tx_par;
		logic              tx_line;
		urm_ser_state_type rx_st;
		logic [3:0]        rx_cnt;
		logic [2:0]        rx_bit;
		logic [7:0]        rx_sh;
		logic              rx_par;
		logic              rx_push;
		logic [7:0]        rx_word;
		logic [2:0]        rx_flags;
		logic [7:0]        rdata;
		logic              txd;
		logic              rts_n;
		logic              dtr_n;
	} urm_state_type;

	urm_state_type s_reg;
	urm_state_type s_next;

	logic       txf_in_valid;
	logic       txf_in_ready;
	logic       txf_valid;
	logic [7:0] txf_data;
	logic       txf_pop;
	logic [4:0] txf_cnt;
	logic       txf_flush;
	logic       rxf_in_valid;
	logic       rxf_in_ready;
	logic       rxf_valid;
	logic [7:0] rxf_data;
	logic       rxf_pop;
	logic [4:0] rxf_cnt;
	logic       rxf_flush;

	// Parity bit that goes with the running XOR of the data bits
	function automatic logic par_bit(input logic x, input logic [7:0] lcr);
		if (lcr[`URM_LCR_STICK])
			return ~lcr[`URM_LCR_EPS];
		return lcr[`URM_LCR_EPS] ? x : ~x;
	endfunction

	function automatic logic [4:0] trig_level(input logic [1:0] sel);
		unique case (sel)
			2'h0: return `URM_TRIG_1;
			2'h1: return `URM_TRIG_4;
			2'h2: return `URM_TRIG_8;
			2'h3: return `URM_TRIG_14;
		endcase
	endfunction

	urm_fifo #(.WIDTH(8), .DEPTH(`URM_FIFO_DEPTH)) u_txf (
		.mclk_i      (mclk_i),
		.srst_i      (srst_i),
		.ce_i        (ce_i),
		.flush_i     (txf_flush),
		.in_valid_i  (txf_in_valid),
		.in_data_i   (wdata_i),
		.in_ready_o  (txf_in_ready),
		.out_valid_o (txf_valid),
		.out_data_o  (txf_data),
		.out_ready_i (txf_pop),
		.count_o     (txf_cnt)
	);

	urm_fifo #(.WIDTH(8), .DEPTH(`URM_FIFO_DEPTH)) u_rxf (
		.mclk_i      (mclk_i),
		.srst_i      (srst_i),
		.ce_i        (ce_i),
		.flush_i     (rxf_flush),
		.in_valid_i  (rxf_in_valid),
		.in_data_i   (s_reg.rx_word),
		.in_ready_o  (rxf_in_ready),
		.out_valid_o (rxf_valid),
		.out_data_o  (rxf_data),
		.out_ready_i (rxf_pop),
		.count_o     (rxf_cnt)
	);

	// ==============================
	// Next-state logic
	always_comb
	begin
		logic        divisor_latch_access;
		logic        lp;
		logic        rxd;
		logic        tx_acc;
		logic        rx_acc;
		logic [3:0]  m;
		logic [2:0]  last;
		logic        pend;
		logic [2:0]  iid;
		logic        tx_fully_empty;
		logic [15:0] div;
		divisor_latch_access = s_reg.lcr[`URM_LCR_DIVISOR_LATCH_ACCESS];
		lp   = s_reg.mcr[`URM_MCR_LOOP];
		rxd  = lp ? s_reg.tx_line : rx_i;
		// Non-FIFO mode behaves as a single holding byte
		tx_acc = s_reg.fifo_en ? txf_in_ready : ~txf_valid;
		rx_acc = s_reg.fifo_en ? rxf_in_ready : ~rxf_valid;
		// Loopback feeds modem status from the control bits
		m = lp ? {s_reg.mcr[`URM_MCR_AUX_OUTPUT_TWO], s_reg.mcr[`URM_MCR_AUX_OUTPUT_ONE],
			s_reg.mcr[`URM_MCR_DTR], s_reg.mcr[`URM_MCR_RTS]}
			: {~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};
		last = 3'(3'h4 + s_reg.lcr[1:0]);
		tx_fully_empty = (s_reg.tx_st == URM_IDLE) & (xt_mode_i | ~txf_valid);      // R03
		div  = {s_reg.dlm, s_reg.dll};

		pend = 1'b1;
		iid  = `URM_IID_MODEM;
		if (s_reg.ier[2] & (|s_reg.lsr_err))
			iid = `URM_IID_LINE;
		else if (s_reg.ier[0] & (s_reg.fifo_en ? (rxf_cnt >= trig_level(s_reg.trig))
			: rxf_valid))                                                  // R11
			iid = `URM_IID_RXDATA;
		else if (s_reg.ier[1] & s_reg.tx_holding_empty_int)
			iid = `URM_IID_TX_HOLDING_EMPTY;
		else if (~(s_reg.ier[3] & (|s_reg.msr_delta)))
			pend = 1'b0;

		s_next         = s_reg;
		s_next.rx_push = 1'b0;
		txf_in_valid   = 1'b0;
		txf_pop        = 1'b0;
		txf_flush      = 1'b0;
		rxf_pop        = 1'b0;
		rxf_flush      = 1'b0;
		rxf_in_valid   = s_reg.rx_push & rx_acc;

		s_next.tick = 1'b0;
		if (s_reg.brg <= 16'h0001)
		begin
			s_next.brg  = div;
			s_next.tick = 1'b1;
		end
		else
			s_next.brg = s_reg.brg - 16'h0001;

		// ==============================
		// Register reads and their side effects
		if (rd_i)
		begin
			unique case (addr_i)
				`URM_OFS_DATA:
				begin
					s_next.rdata = divisor_latch_access ? s_reg.dll : rxf_data;               // R01 R08
					rxf_pop      = ~divisor_latch_access;
				end
				`URM_OFS_IER: s_next.rdata = divisor_latch_access ? s_reg.dlm : {4'h0, s_reg.ier};
				`URM_OFS_IIR_FCR:
				begin
					s_next.rdata = {{2{s_reg.fifo_en}}, 2'h0, iid & {3{pend}}, ~pend}; // R06 R14
					if (pend && iid == `URM_IID_TX_HOLDING_EMPTY)
						s_next.tx_holding_empty_int = 1'b0;
				end
				`URM_OFS_LCR: s_next.rdata = s_reg.lcr;
				`URM_OFS_MCR: s_next.rdata = {3'h0, s_reg.mcr};
				`URM_OFS_LSR:
				begin
					s_next.rdata = {s_reg.fifo_en & (|s_reg.lsr_err[3:1]), tx_fully_empty,   // R06
						~txf_valid, s_reg.lsr_err, rxf_valid};                     // R13
					s_next.lsr_err = 4'h0;
				end
				`URM_OFS_MSR:
				begin
					s_next.rdata     = {m, s_reg.msr_delta};
					s_next.msr_delta = 4'h0;
				end
				`URM_OFS_SCR: s_next.rdata = xt_mode_i ? `URM_RST_BYTE : s_reg.scr; // R05
			endcase
		end

		// ==============================
		// Register writes
		if (wr_i)
		begin
			unique case (addr_i)
				`URM_OFS_DATA:
					if (divisor_latch_access)
						s_next.dll = wdata_i;                                    // R01
					else
					begin
						txf_in_valid    = tx_acc;
						s_next.tx_holding_empty_int = 1'b0;
					end
				`URM_OFS_IER:
					if (divisor_latch_access)
						s_next.dlm = wdata_i;
					else
					begin
						s_next.ier = wdata_i[3:0];
						if (wdata_i[1] & ~s_reg.ier[1] & ~txf_valid)
							s_next.tx_holding_empty_int = 1'b1;
					end
				`URM_OFS_IIR_FCR:
				begin
					// Bit 3 selects DMA mode, which does not exist, so it is dropped
					s_next.fifo_en = wdata_i[`URM_FCR_EN];                       // R07
					s_next.trig    = wdata_i[7:6];                               // R11
					rxf_flush = ~wdata_i[`URM_FCR_EN] | wdata_i[`URM_FCR_RXCLR] // R09 R10
						| (wdata_i[`URM_FCR_EN] ^ s_reg.fifo_en);
					txf_flush = ~wdata_i[`URM_FCR_EN] | wdata_i[`URM_FCR_TXCLR] // R09
						| (wdata_i[`URM_FCR_EN] ^ s_reg.fifo_en);
				end
				`URM_OFS_LCR: s_next.lcr = wdata_i;
				`URM_OFS_MCR: s_next.mcr = wdata_i[4:0];                        // R04
				`URM_OFS_SCR:
					if (!xt_mode_i)
						s_next.scr = wdata_i;                                    // R05
				default: ;
			endcase
		end

		// ==============================
		// Transmitter, one bit per sixteen ticks
		if (s_reg.tick)
		begin
			s_next.tx_cnt = 4'(s_reg.tx_cnt + 1'b1);
			unique case (s_reg.tx_st)
				URM_IDLE:
				begin
					s_next.tx_cnt = 4'h0;
					// Shifter reloads only once the last stop bit has gone out
					if (txf_valid)
					begin
						txf_pop        = 1'b1;                                   // R12
						s_next.tx_sh   = txf_data;
						s_next.tx_par  = 1'b0;
						s_next.tx_line = 1'b0;
						s_next.tx_st   = URM_START;
					end
				end
				URM_START:
					if (s_reg.tx_cnt == `URM_OVS_LAST)
					begin
						s_next.tx_line = s_reg.tx_sh[0];                         // R02
						s_next.tx_bit  = 3'h0;
						s_next.tx_st   = URM_DATA;
					end
				URM_DATA:
					if (s_reg.tx_cnt == `URM_OVS_LAST)
					begin
						s_next.tx_par = s_reg.tx_par ^ s_reg.tx_sh[0];
						s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
						s_next.tx_bit = 3'(s_reg.tx_bit + 1'b1);
						s_next.tx_line = s_reg.tx_sh[1];
						if (s_reg.tx_bit == last)
						begin
							s_next.tx_bit = 3'h0;
							if (s_reg.lcr[`URM_LCR_PEN])
							begin
								s_next.tx_line = par_bit(s_next.tx_par, s_reg.lcr);
								s_next.tx_st   = URM_PAR;
							end
							else
							begin
								s_next.tx_line = 1'b1;
								s_next.tx_st   = URM_STOP;
							end
						end
					end
				URM_PAR:
					if (s_reg.tx_cnt == `URM_OVS_LAST)
					begin
						s_next.tx_line = 1'b1;
						s_next.tx_st   = URM_STOP;
					end
				URM_STOP:
					if (s_reg.tx_cnt == `URM_OVS_LAST)
					begin
						s_next.tx_bit = 3'h1;
						if (s_reg.tx_bit[0] | ~s_reg.lcr[`URM_LCR_STB])
							s_next.tx_st = URM_IDLE;
					end
				default: s_next.tx_st = URM_IDLE;
			endcase
			if (txf_pop && txf_cnt == 5'h01)
				s_next.tx_holding_empty_int = 1'b1;
		end

		// ==============================
		// Receiver, sampling mid-bit
		if (s_reg.tick)
		begin
			s_next.rx_cnt = 4'(s_reg.rx_cnt + 1'b1);
			unique case (s_reg.rx_st)
				URM_IDLE:
				begin
					s_next.rx_cnt = 4'h0;
					if (!rxd)
						s_next.rx_st = URM_START;
				end
				URM_START:
					if (s_reg.rx_cnt == `URM_OVS_HALF)
					begin
						s_next.rx_cnt = 4'h0;
						s_next.rx_bit = 3'h0;
						s_next.rx_par = 1'b0;
						s_next.rx_st  = rxd ? URM_IDLE : URM_DATA;
					end
				URM_DATA:
					if (s_reg.rx_cnt == `URM_OVS_LAST)
					begin
						s_next.rx_sh  = {rxd, s_reg.rx_sh[7:1]};                 // R02
						s_next.rx_par = s_reg.rx_par ^ rxd;
						s_next.rx_bit = 3'(s_reg.rx_bit + 1'b1);
						if (s_reg.rx_bit == last)
							s_next.rx_st = s_reg.lcr[`URM_LCR_PEN] ? URM_PAR : URM_STOP;
					end
				URM_PAR:
					if (s_reg.rx_cnt == `URM_OVS_LAST)
					begin
						s_next.rx_flags[0] = rxd ^ par_bit(s_reg.rx_par, s_reg.lcr);
						s_next.rx_st = URM_STOP;
					end
				URM_STOP:
					if (s_reg.rx_cnt == `URM_OVS_LAST)
					begin
						s_next.rx_word = s_reg.rx_sh >> (2'h3 - s_reg.lcr[1:0]);
						s_next.rx_flags[1] = ~rxd;
						s_next.rx_flags[2] = ~rxd & (s_reg.rx_sh == 8'h00);
						s_next.rx_push = 1'b1;
						s_next.rx_st   = URM_IDLE;
					end
				default: s_next.rx_st = URM_IDLE;
			endcase
		end
		if (s_reg.rx_st == URM_IDLE)
			s_next.rx_flags[0] = 1'b0;

		// ==============================
		// Sticky status: a new event outweighs a clear in the same cycle
		if (s_reg.rx_push)
			s_next.lsr_err = s_next.lsr_err | {s_reg.rx_flags, ~rx_acc};
		s_next.msr_last  = m;
		s_next.msr_delta = s_next.msr_delta | {m[3] ^ s_reg.msr_last[3],
			s_reg.msr_last[2] & ~m[2], m[1] ^ s_reg.msr_last[1], m[0] ^ s_reg.msr_last[0]};

		// Break and loopback hold the pin; the auxiliary bits never reach one
		s_next.txd   = lp | (s_next.tx_line & ~s_next.lcr[`URM_LCR_BREAK]);
		s_next.rts_n = lp | ~s_next.mcr[`URM_MCR_RTS];
		s_next.dtr_n = lp | ~s_next.mcr[`URM_MCR_DTR];                       // R04
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			s_reg          <= '0;
			s_reg.tx_st    <= URM_IDLE;
			s_reg.rx_st    <= URM_IDLE;
			s_reg.tx_line  <= 1'b1;
			s_reg.txd      <= 1'b1;
			s_reg.rts_n    <= 1'b1;
			s_reg.dtr_n    <= 1'b1;
			s_reg.msr_last <= {~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};
		end
		else if (ce_i)
			s_reg <= s_next;
	end

	assign rdata_o = s_reg.rdata;
	assign tx_o    = s_reg.txd;
	assign rts_n_o = s_reg.rts_n;
	assign dtr_n_o = s_reg.dtr_n;
endmodule // urm_uart

// ---- urm_uart_monitor.sv ----
// Concurrent checks on the serial port register set
`timescale 1ns/1ps
module urm_uart_monitor (
	input wire logic       mclk_i,
	input wire logic       srst_i,
	input wire logic       ce_i,
	input wire logic [2:0] addr_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic       xt_mode_i,
	input wire logic       rx_i,
	input wire logic       tx_o,
	input wire logic       cts_n_i,
	input wire logic       dsr_n_i,
	input wire logic       ri_n_i,
	input wire logic       dcd_n_i,
	input wire logic       rts_n_o,
	input wire logic       dtr_n_o
);
	// ==========
	// Shadow of host-written state, so reads can be predicted
	logic [7:0] lcr_reg;
	logic [7:0] dll_reg;
	logic [3:0] ier_reg;
	logic       fifo_on_reg;
	wire        rd_ok = ce_i && rd_i;
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			lcr_reg <= 8'h00;
			dll_reg <= 8'h00;
			ier_reg <= 4'h0;
			fifo_on_reg <= 1'b0;
		end
		else if (ce_i && wr_i)
		begin
			if (addr_i == 3'h3) lcr_reg <= wdata_i;
			if (addr_i == 3'h0 && lcr_reg[7]) dll_reg <= wdata_i;
			if (addr_i == 3'h1 && !lcr_reg[7]) ier_reg <= wdata_i[3:0];
			if (addr_i == 3'h2) fifo_on_reg <= wdata_i[0];
		end
	end
	// ==========
	// Assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	property modem_pins_p;
		logic [7:0] w;
		(ce_i && wr_i && addr_i == 3'h4, w = wdata_i) |-> ##2
			(w[4] ? rts_n_o && dtr_n_o : rts_n_o == !w[1] && dtr_n_o == !w[0]);
	endproperty
	reset_outs_a: assert property ($fell(srst_i) |-> tx_o && rts_n_o && dtr_n_o
		&& rdata_o == 8'h00) else $error("outputs not idle after reset");
	rdata_hold_a: assert property (!rd_ok |=> $stable(rdata_o))
		else $error("read data moved without a read");
	div_low_read_a: assert property (rd_ok && lcr_reg[7] && addr_i == 3'h0
		|=> rdata_o == $past(dll_reg)) else $error("divisor low byte not read back");
	line_ctl_read_a: assert property (rd_ok && addr_i == 3'h3
		|=> rdata_o == $past(lcr_reg)) else $error("line control not read back");
	scratch_xt_a: assert property (rd_ok && xt_mode_i && addr_i == 3'h7
		|=> rdata_o == 8'h00) else $error("scratch visible in XT mode");
	nofifo_ident_a: assert property (rd_ok && !fifo_on_reg && addr_i == 3'h2
		|=> rdata_o[7:6] == 2'b00 && !rdata_o[3]) else $error("FIFO bits set in non-FIFO mode");
	ident_idle_a: assert property (rd_ok && addr_i == 3'h2 && ier_reg == 4'h0
		|=> rdata_o[0]) else $error("pending shown with all sources off");
	modem_pins_a: assert property (modem_pins_p)
		else $error("modem pins do not follow control bits");
	cover property (rd_ok && lcr_reg[7] && addr_i == 3'h0);
	cover property (rd_ok && addr_i == 3'h2 ##1 !rdata_o[0]);
	cover property (rd_ok && xt_mode_i && addr_i == 3'h7);
endmodule // urm_uart_monitor

bind urm_uart urm_uart_monitor mon (.mclk_i, .srst_i, .ce_i, .addr_i, .wr_i, .rd_i,
	.wdata_i, .rdata_o, .xt_mode_i, .rx_i, .tx_o, .cts_n_i, .dsr_n_i, .ri_n_i,
	.dcd_n_i, .rts_n_o, .dtr_n_o);

// ---- urm_peer.sv ----
// Serial peer: sends and receives 8-bit frames with one stop bit
`timescale 1ns/1ps
module urm_peer #(
	parameter int BIT = 32
) (
	input  wire logic       mclk_i,
	input  wire logic       line_i,
	output logic            line_o,
	output logic            got_o,
	output logic      [7:0] byte_o
);
	initial
	begin
		line_o = 1'b1;
		got_o = 1'b0;
		byte_o = 8'h00;
	end
	// Sample mid-bit; a low stop bit gives no pulse, so the byte shows as lost
	always
	begin
		@(negedge line_i);
		repeat (BIT / 2) @(posedge mclk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge mclk_i);
			byte_o[i] <= line_i;
		end
		repeat (BIT) @(posedge mclk_i);
		got_o <= line_i;
		@(posedge mclk_i);
		got_o <= 1'b0;
	end
	task send(input logic [7:0] b);
		@(posedge mclk_i);
		line_o <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge mclk_i);
			line_o <= b[i];
		end
		repeat (BIT) @(posedge mclk_i);
		line_o <= 1'b1;
		repeat (BIT + 2) @(posedge mclk_i);
	endtask
endmodule // urm_peer

// ---- tb.sv ----
// Self-checking bench for the serial port register set
`timescale 1ns/1ps
module tb;
	localparam int DIV = 2;
	logic       mclk_i, srst_i, rd_i, wr_i, xt_mode_i, cts_n_i;
	logic [2:0] addr_i;
	logic [7:0] wdata_i, rdata_o, b, m;
	logic       tx_o, rx_i, rts_n_o, dtr_n_o, got, rd_pend;
	logic [7:0] got_byte;
	logic [7:0] exp_q[$], msk_q[$], tx_q[$], rq[$];
	logic [31:0] rng = 32'd47;
	int         error_cnt = 0;
	int         n_tests = 0;
	int         lv[4] = '{1, 4, 8, 14};
	logic [7:0] rst_v[8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00};

	urm_uart dut (.mclk_i, .srst_i, .ce_i(1'b1), .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
		.xt_mode_i, .rx_i, .tx_o, .cts_n_i, .dsr_n_i(1'b1), .ri_n_i(1'b1), .dcd_n_i(1'b1),
		.rts_n_o, .dtr_n_o);
	urm_peer #(.BIT(16 * DIV)) peer (.mclk_i, .line_i(tx_o), .line_o(rx_i), .got_o(got),
		.byte_o(got_byte));

	// ==========
	// Helpers
	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task give_verdict();
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] mk);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		exp_q.push_back(e & mk);
		msk_q.push_back(mk);
		@(posedge mclk_i);
		rd_i <= 1'b0;
	endtask
	task tx_drain();
		for (int i = 0; i < 3000 && tx_q.size() > 0; i++) @(posedge mclk_i);
		repeat (40) @(posedge mclk_i);
	endtask

	// ==========
	// Result watcher: read data lands the cycle after the strobe
	always @(posedge mclk_i)
	begin
		if (rd_pend)
		begin
			m = msk_q.pop_front();
			check("rdata", rdata_o & m, exp_q.pop_front());
		end
		rd_pend <= rd_i;
		if (got) check("tx_byte", got_byte, tx_q.pop_front());
	end

	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	initial
	begin
		repeat (60000) @(posedge mclk_i);
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		srst_i = 1'b1;
		{rd_i, wr_i, xt_mode_i, rd_pend} = 4'h0;
		cts_n_i = 1'b1;
		addr_i = 3'h0;
		wdata_i = 8'h00;
		repeat (5) @(posedge mclk_i);
		srst_i <= 1'b0;
		for (int a = 1; a < 8; a++) rd(a[2:0], rst_v[a], a == 6 ? 8'h0F : 8'hFF);
		wr(3'h3, 8'h83);
		wr(3'h0, DIV[7:0]);
		b = rnd();
		wr(3'h1, b);
		rd(3'h1, b, 8'hFF);
		wr(3'h1, 8'h00);
		rd(3'h0, DIV[7:0], 8'hFF);
		rd(3'h3, 8'h83, 8'hFF);
		wr(3'h3, 8'h03);
		rd(3'h1, 8'h00, 8'hFF);
		// A random high divisor byte may sit in the baud counter; a reset clears it
		@(posedge mclk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'b0;
		wr(3'h3, 8'h83);
		wr(3'h0, DIV[7:0]);
		wr(3'h3, 8'h03);
		rd(3'h3, 8'h03, 8'hFF);
		b = rnd();
		wr(3'h7, b);
		rd(3'h7, b, 8'hFF);
		xt_mode_i <= 1'b1;
		wr(3'h7, ~b);
		rd(3'h7, 8'h00, 8'hFF);
		xt_mode_i <= 1'b0;
		rd(3'h7, b, 8'hFF);
		wr(3'h4, 8'h0C);
		repeat (2) @(posedge mclk_i);
		#1 check("pins", {6'h00, rts_n_o, dtr_n_o}, 8'h03);
		wr(3'h4, 8'h03);
		rd(3'h4, 8'h03, 8'hFF);
		cts_n_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		rd(3'h6, 8'h11, 8'h11);
		rd(3'h6, 8'h10, 8'h11);
		// Second byte must wait in holding; a third is refused while it waits
		b = rnd();
		wr(3'h0, b);
		tx_q.push_back(b);
		repeat (8) @(posedge mclk_i);
		b = rnd();
		wr(3'h0, b);
		tx_q.push_back(b);
		wr(3'h0, rnd());
		rd(3'h5, 8'h00, 8'h60);
		xt_mode_i <= 1'b1;
		tx_drain();
		rd(3'h5, 8'h60, 8'h60);
		xt_mode_i <= 1'b0;
		b = rnd();
		peer.send(b);
		rd(3'h5, 8'h01, 8'h01);
		wr(3'h0, ~b);
		tx_q.push_back(~b);
		rd(3'h0, b, 8'hFF);
		rd(3'h5, 8'h00, 8'h01);
		wr(3'h1, 8'h01);
		for (int k = 0; k < 4; k++)
		begin
			wr(3'h2, {k[1:0], 6'h0B});
			rq.delete();
			for (int i = 1; i < lv[k]; i++)
			begin
				rq.push_back(rnd());
				peer.send(rq[$]);
			end
			rd(3'h2, 8'hC1, 8'hFF);
			rq.push_back(rnd());
			peer.send(rq[$]);
			rd(3'h2, 8'hC4, 8'hFF);
		end
		for (int i = 0; i < 3; i++)
		begin
			rq.push_back(rnd());
			peer.send(rq[$]);
		end
		rd(3'h5, 8'h63, 8'hFF);
		for (int i = 0; i < 16; i++) rd(3'h0, rq[i], 8'hFF);
		rd(3'h5, 8'h60, 8'hFF);
		peer.send(rnd());
		wr(3'h2, 8'h00);
		rd(3'h5, 8'h60, 8'hFF);
		rd(3'h2, 8'h01, 8'hFF);
		tx_drain();
		give_verdict();
	end
endmodule // tb
